// File: rtl/audio_adc_interrupt_logic.sv
// Purpose: interrupt latching, masking and pin drive of the audio converter
// Assumes: register port sits behind the serial control bus decoder
// Notes: event inputs are one-cycle strobes synchronous to I_CLK
//
// Contract
// - polarity bit 7: 0 low-active, 1 high-active
// - mode 0: assert while unmasked flag set
// - mode 2: 2 ms high every 4 ms
// - mode 3: a 2 ms pulse per event; an event during the pulse restarts the 2 ms
// - readback select shows all or unmasked flags
// - mask bits 7..3 per source, 1 masks
// - mask register resets to all ones
// - bit 7 clock error, clears on read
// - bit 6 PLL lock, clears on read
// - bit 5 mixing saturation, clears on read
// - bit 4 voice power-up, clears on read
// - bit 3 voice power-down, clears on read
// - latched register resets to zero
// - config register resets to zero
// - pin carries interrupt only at function 2
`timescale 1ns/100ps
`default_nettype none
module audio_adc_interrupt_logic #(
   parameter int PULSE_HIGH_CYC = irq_logic_pkg::PULSE_HIGH_CYC,
   parameter int PULSE_PERIOD_CYC = irq_logic_pkg::PULSE_PERIOD_CYC
) (
   input wire logic I_CLK,          // 20 MHz device clock
   input wire logic I_RSTN,         // synchronous reset, active low
   input wire logic [7:0] I_ADDR,   // register address
   input wire logic I_WR,           // write strobe
   input wire logic I_RD,           // read strobe
   input wire logic [7:0] I_WDATA,  // write data
   output logic [7:0] O_RDATA,      // read data, held until next read
   output logic O_RVALID,           // read data valid pulse
   input wire logic I_EVT_CLK_ERR,  // audio_serial_port clock error
   input wire logic I_EVT_PLL_LOCK, // PLL achieved lock
   input wire logic I_EVT_MIX_SAT,  // input mixing saturation alert
   input wire logic I_EVT_VAD_UP,   // voice_activity_detect power-up
   input wire logic I_EVT_VAD_DOWN, // voice_activity_detect power-down
   output logic O_MFP1_OUT,         // multi_function_pin_one level
   output logic O_MFP1_OE_N,        // pin drive enable, low drives
   output logic O_IRQ_ASSERTED      // internal interrupt, active high
);
   localparam int N = irq_logic_pkg::NUM_SRC;
   localparam int LSB = irq_logic_pkg::SRC_LSB;

   irq_logic_pkg::reg_req_s req;
   assign req = '{addr: I_ADDR, wr: I_WR, rd: I_RD, wdata: I_WDATA};

   logic [7:0] config_reg, mask_reg, mfp1_cfg_reg;
   logic [N-1:0] flag_reg, flag_next;
   logic [7:0] rdata_next;

   wire [N-1:0] evt = {I_EVT_CLK_ERR, I_EVT_PLL_LOCK, I_EVT_MIX_SAT,
                       I_EVT_VAD_UP, I_EVT_VAD_DOWN};

   wire sel_config = (req.addr == irq_logic_pkg::IRQ_CONFIG_ADDR);
   wire sel_mask = (req.addr == irq_logic_pkg::IRQ_MASK_ADDR);
   wire sel_flags = (req.addr == irq_logic_pkg::IRQ_LATCHED_FLAGS_ADDR);
   wire sel_mfp1 = (req.addr == irq_logic_pkg::MFP1_CFG_ADDR);

   wire polarity = config_reg[irq_logic_pkg::POLARITY_BIT];
   wire [1:0] mode = config_reg[irq_logic_pkg::EVENT_MODE_HI:
                                irq_logic_pkg::EVENT_MODE_LO];
   wire readback_sel = config_reg[irq_logic_pkg::READBACK_SEL_BIT];
   wire [N-1:0] src_mask = mask_reg[LSB+N-1:LSB];
   wire [N-1:0] unmasked_flags = flag_reg & ~src_mask;
   wire [N-1:0] unmasked_evt = evt & ~src_mask;
   wire pending = |unmasked_flags;
   wire new_event = |unmasked_evt;

   // shown flags, in place within the byte; low bits read zero
   wire [N-1:0] shown_flags = readback_sel ? unmasked_flags
                                           : flag_reg;
   wire [7:0] flags_byte = {shown_flags, {LSB{1'b0}}};
   wire read_flags = req.rd && sel_flags;

   // per-source latch: a new event in the read cycle survives the clear
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_flag
         assign flag_next[g] = evt[g] ||
                               (flag_reg[g] && !(read_flags && shown_flags[g]));
      end
   endgenerate

   assign rdata_next = sel_config ? config_reg :
                       sel_mask ? mask_reg :
                       sel_flags ? flags_byte :
                       sel_mfp1 ? mfp1_cfg_reg : 8'h00;

   always_ff @(posedge I_CLK) begin
      if (!I_RSTN) begin
         config_reg <= irq_logic_pkg::IRQ_CONFIG_RESET;
         mask_reg <= irq_logic_pkg::IRQ_MASK_RESET;
         mfp1_cfg_reg <= irq_logic_pkg::MFP1_CFG_RESET;
      end else if (req.wr) begin
         if (sel_config) begin
            config_reg <= req.wdata & irq_logic_pkg::IRQ_CONFIG_WMASK;
         end
         if (sel_mask) begin
            mask_reg <= req.wdata;
         end
         if (sel_mfp1) begin
            mfp1_cfg_reg <= req.wdata & irq_logic_pkg::MFP1_CFG_WMASK;
         end
      end
   end

   always_ff @(posedge I_CLK) begin
      if (!I_RSTN) begin
         flag_reg <= '0;
         O_RDATA <= 8'h00;
         O_RVALID <= 1'b0;
      end else begin
         flag_reg <= flag_next;
         O_RVALID <= req.rd;
         if (req.rd) begin
            O_RDATA <= rdata_next;
         end
      end
   end

   // pulse timing for modes 2 and 3
   logic timed_pulse;
   irq_pulse_timer #(
      .HIGH_CYC(PULSE_HIGH_CYC),
      .PERIOD_CYC(PULSE_PERIOD_CYC),
      .W(irq_logic_pkg::TIMER_W)
   ) u_timer (
      .i_clk(I_CLK),
      .i_rstn(I_RSTN),
      .i_repeat(mode == irq_logic_pkg::MODE_REPEAT),
      .i_run(pending),
      .i_trig(new_event && (mode == irq_logic_pkg::MODE_ONESHOT)),
      .o_pulse(timed_pulse)
   );

   // reserved mode 1 keeps the line idle rather than guessing a meaning
   logic irq_next;
   always_comb begin
      unique case (mode)
         irq_logic_pkg::MODE_LEVEL: irq_next = pending;
         irq_logic_pkg::MODE_RESERVED: irq_next = 1'b0;
         irq_logic_pkg::MODE_REPEAT: irq_next = timed_pulse;
         irq_logic_pkg::MODE_ONESHOT: irq_next = timed_pulse;
      endcase
   end

   wire irq_pin_level = polarity ? irq_next : !irq_next;
   wire mfp1_is_irq = (mfp1_cfg_reg[irq_logic_pkg::MFP1_FUNC_HI:
                       irq_logic_pkg::MFP1_FUNC_LO] ==
                       irq_logic_pkg::MFP1_FUNC_IRQ);

   // other pin functions are outside this block, so the pin floats then
   always_ff @(posedge I_CLK) begin
      if (!I_RSTN) begin
         O_IRQ_ASSERTED <= 1'b0;
         O_MFP1_OUT <= 1'b1;
         O_MFP1_OE_N <= 1'b1;
      end else begin
         O_IRQ_ASSERTED <= irq_next;
         O_MFP1_OUT <= mfp1_is_irq ? irq_pin_level : 1'b1;
         O_MFP1_OE_N <= !mfp1_is_irq;
      end
   end
endmodule // audio_adc_interrupt_logic
`default_nettype wire

// File: rtl/irq_logic_pkg.sv
// Purpose: shared constants and types for the audio converter interrupt logic
// Assumes: 20 MHz device clock, byte-wide control registers
// Notes: register offsets are byte addresses on the control bus
package irq_logic_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int NUM_SRC = 5;

   // register offsets
   localparam logic [7:0] MFP1_CFG_ADDR = 8'h21;
   localparam logic [7:0] IRQ_CONFIG_ADDR = 8'h32;
   localparam logic [7:0] IRQ_MASK_ADDR = 8'h33;
   localparam logic [7:0] IRQ_LATCHED_FLAGS_ADDR = 8'h36;

   // reset values
   localparam logic [7:0] MFP1_CFG_RESET = 8'h22;
   localparam logic [7:0] IRQ_CONFIG_RESET = 8'h00;
   localparam logic [7:0] IRQ_MASK_RESET = 8'hFF;
   localparam logic [7:0] IRQ_LATCHED_FLAGS_RESET = 8'h00;

   // irq_config fields
   localparam int POLARITY_BIT = 7;
   localparam int EVENT_MODE_HI = 6;
   localparam int EVENT_MODE_LO = 5;
   localparam int READBACK_SEL_BIT = 2;
   localparam logic [7:0] IRQ_CONFIG_WMASK = 8'hE4;

   // pin config: function field and writable bits (bit 3 reads zero)
   localparam int MFP1_FUNC_HI = 7;
   localparam int MFP1_FUNC_LO = 4;
   localparam logic [7:0] MFP1_CFG_WMASK = 8'hF7;
   localparam logic [3:0] MFP1_FUNC_IRQ = 4'h2;

   // event sources sit in bits 7..3 of mask and latched registers
   localparam int SRC_LSB = 3;
   localparam int SRC_CLK_ERR = 4;
   localparam int SRC_PLL_LOCK = 3;
   localparam int SRC_MIX_SAT = 2;
   localparam int SRC_VAD_UP = 1;
   localparam int SRC_VAD_DOWN = 0;

   // event mode codes
   localparam logic [1:0] MODE_LEVEL = 2'h0;
   localparam logic [1:0] MODE_RESERVED = 2'h1;
   localparam logic [1:0] MODE_REPEAT = 2'h2;
   localparam logic [1:0] MODE_ONESHOT = 2'h3;

   // pulse timing
   localparam int CLK_MHZ = 20;
   localparam int PULSE_HIGH_US = 2000;
   localparam int PULSE_PERIOD_US = 4000;
   localparam int PULSE_HIGH_CYC = PULSE_HIGH_US * CLK_MHZ;
   localparam int PULSE_PERIOD_CYC = PULSE_PERIOD_US * CLK_MHZ;
   localparam int TIMER_W = 17;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic wr;
      logic rd;
      logic [DATA_W-1:0] wdata;
   } reg_req_s;
endpackage

// File: rtl/irq_pulse_timer.sv
// Purpose: timed pulse generator for the repeating and one-shot modes
// Assumes: i_trig is a one-cycle strobe, i_run a level
// Notes: a new trigger during a one-shot restarts the full high time
`timescale 1ns/100ps
`default_nettype none
module irq_pulse_timer #(
   parameter int HIGH_CYC = irq_logic_pkg::PULSE_HIGH_CYC,
   parameter int PERIOD_CYC = irq_logic_pkg::PULSE_PERIOD_CYC,
   parameter int W = irq_logic_pkg::TIMER_W
) (
   input wire logic i_clk,    // device clock
   input wire logic i_rstn,   // synchronous reset, active low
   input wire logic i_repeat, // 1 = repeating train, 0 = one-shot
   input wire logic i_run,    // repeating: train runs while high
   input wire logic i_trig,   // one-shot: start a pulse
   output logic o_pulse       // pulse output, registered
);
   localparam logic [W-1:0] HIGH_LAST = W'(HIGH_CYC - 1);
   localparam logic [W-1:0] HIGH_N = W'(HIGH_CYC);
   localparam logic [W-1:0] PERIOD_LAST = W'(PERIOD_CYC - 1);

   logic [W-1:0] cnt_reg, cnt_next;
   logic busy_reg, busy_next;
   logic pulse_next;

   wire period_end = (cnt_reg == PERIOD_LAST);
   wire high_end = (cnt_reg == HIGH_LAST);

   always_comb begin
      cnt_next = cnt_reg;
      busy_next = busy_reg;
      if (i_repeat) begin
         // train restarts from its high phase whenever pending returns
         if (!i_run) begin
            cnt_next = '0;
            busy_next = 1'b0;
         end else begin
            busy_next = 1'b1;
            cnt_next = (busy_reg && !period_end) ? cnt_reg + 1'b1 : '0;
         end
      end else if (i_trig) begin
         cnt_next = '0;
         busy_next = 1'b1;
      end else if (busy_reg) begin
         busy_next = !high_end;
         cnt_next = high_end ? '0 : cnt_reg + 1'b1;
      end
      pulse_next = busy_next && (cnt_next < HIGH_N);
   end

   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         cnt_reg <= '0;
         busy_reg <= 1'b0;
         o_pulse <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         busy_reg <= busy_next;
         o_pulse <= pulse_next;
      end
   end
endmodule // irq_pulse_timer
`default_nettype wire

// File: test/irq_logic_chk.sv
// Purpose: port checker for the interrupt logic
// Assumes: shadow registers follow host writes at the ports
// Notes: attached by bind below
`timescale 1ns/100ps
`default_nettype none
module irq_logic_chk #(
   parameter int PULSE_HIGH_CYC = 4,
   parameter int PULSE_PERIOD_CYC = 8
) (
   input wire logic I_CLK, I_RSTN, I_WR, I_RD, // clock, reset, strobes
   input wire logic [7:0] I_ADDR, I_WDATA, O_RDATA, // register port
   input wire logic O_RVALID, O_MFP1_OUT, O_MFP1_OE_N, O_IRQ_ASSERTED,
   input wire logic I_EVT_CLK_ERR, I_EVT_PLL_LOCK, I_EVT_MIX_SAT,
   input wire logic I_EVT_VAD_UP, I_EVT_VAD_DOWN // event strobes
);
   logic [7:0] cfg_reg, mask_reg;
   int hi_reg;
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_RSTN);
   always_ff @(posedge I_CLK) begin
      if (!I_RSTN) begin
         cfg_reg <= 8'h00;
         mask_reg <= 8'hFF;
      end else if (I_WR && I_ADDR == 8'h32) begin
         cfg_reg <= I_WDATA & 8'hE4;
      end else if (I_WR && I_ADDR == 8'h33) begin
         mask_reg <= I_WDATA;
      end
   end
   // length of the current high stretch, bounds both timed modes
   always_ff @(posedge I_CLK) begin
      hi_reg <= (O_IRQ_ASSERTED && I_RSTN) ? hi_reg + 1 : 0;
   end
   a_read_answer: assert property (I_RD |=> O_RVALID)
      else $error("read not answered");
   a_valid_cause: assert property (O_RVALID |-> $past(I_RD))
      else $error("valid without read");
   a_config_read: assert property (I_RD && I_ADDR == 8'h32
      |=> O_RDATA == $past(cfg_reg)) else $error("config readback");
   a_mask_read: assert property (I_RD && I_ADDR == 8'h33
      |=> O_RDATA == $past(mask_reg)) else $error("mask readback");
   a_flag_read: assert property (I_EVT_CLK_ERR ##1 !I_RD
      ##1 (I_RD && I_ADDR == 8'h36 && !cfg_reg[2]) |=> O_RDATA[7])
      else $error("clock error flag lost");
   a_masked_quiet: assert property (
      (mask_reg[7:3] == 5'h1F && cfg_reg[6:5] == 2'h0)[*3]
      |-> !O_IRQ_ASSERTED) else $error("masked sources raise interrupt");
   a_pin_level: assert property (!O_MFP1_OE_N
      |-> O_MFP1_OUT == (O_IRQ_ASSERTED ~^ $past(cfg_reg[7])))
      else $error("pin polarity wrong");
   // hi_reg still holds the full run length in the first low cycle
   a_pulse_bound: assert property (cfg_reg[6]
      && O_IRQ_ASSERTED |-> hi_reg < PULSE_HIGH_CYC)
      else $error("timed pulse too long");
endmodule // irq_logic_chk
bind audio_adc_interrupt_logic irq_logic_chk #(
   .PULSE_HIGH_CYC(PULSE_HIGH_CYC), .PULSE_PERIOD_CYC(PULSE_PERIOD_CYC)
) chk_u (.I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_WR(I_WR), .I_RD(I_RD),
   .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .O_RDATA(O_RDATA),
   .O_RVALID(O_RVALID), .O_MFP1_OUT(O_MFP1_OUT), .O_MFP1_OE_N(O_MFP1_OE_N),
   .O_IRQ_ASSERTED(O_IRQ_ASSERTED), .I_EVT_CLK_ERR(I_EVT_CLK_ERR),
   .I_EVT_PLL_LOCK(I_EVT_PLL_LOCK), .I_EVT_MIX_SAT(I_EVT_MIX_SAT),
   .I_EVT_VAD_UP(I_EVT_VAD_UP), .I_EVT_VAD_DOWN(I_EVT_VAD_DOWN));
`default_nettype wire

// File: test/irq_host_model.sv
// Purpose: host side, register master and interrupt input
// Assumes: pull-up on the shared pin
// Notes: tasks are called by the bench
`timescale 1ns/100ps
`default_nettype none
module irq_host_model (
   input wire logic i_clk, // device clock
   input wire logic [7:0] i_rdata, // read data
   input wire logic i_rvalid, // read valid
   input wire logic i_pin_out, // pin level
   input wire logic i_pin_oe_n, // pin enable, low drives
   output logic [7:0] o_addr, // address
   output logic o_wr, // write strobe
   output logic o_rd, // read strobe
   output logic [7:0] o_wdata, // write data
   output logic o_pin // wire level seen by host
);
   assign o_pin = i_pin_oe_n ? 1'b1 : i_pin_out;
   initial begin
      o_addr = 8'h00;
      o_wdata = 8'h00;
      o_wr = 1'b0;
      o_rd = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      #1;
      if (a == 8'h32 && d[6:5] == 2'h1) d[6:5] = 2'h0;
      o_addr = a;
      o_wdata = d;
      o_wr = 1'b1;
      @(posedge i_clk);
      #1;
      o_wr = 1'b0;
      o_addr = ~a;
      o_wdata = ~d;
   endtask
   // an unanswered read returns unknowns so it never matches
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_clk);
      #1;
      o_addr = a;
      o_rd = 1'b1;
      @(posedge i_clk);
      #1;
      o_rd = 1'b0;
      o_addr = ~a;
      d = i_rvalid ? i_rdata : 8'hXX;
   endtask
endmodule // irq_host_model
`default_nettype wire

// File: test/testbench.sv
// Purpose: self-checking bench for the interrupt logic
// Assumes: short pulse timing, 4 high of 8
// Notes: table of register cases, then hand tests
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin mismatches++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module testbench;
   typedef struct {logic [7:0] a; logic [7:0] d; bit w; logic [7:0] e;} row_s;
   logic clk, rstn, wr, rd, pin, oe_n, out, irq, rvalid;
   logic [7:0] addr, wdata, rdata, got;
   logic [4:0] evt;
   int mismatches = 0;
   int total_checks = 0;
   int n;
   row_s rows[9] = '{'{8'h32, 8'h00, 0, 8'h00}, '{8'h33, 8'h00, 0, 8'hFF},
      '{8'h36, 8'h00, 0, 8'h00}, '{8'h32, 8'hFF, 1, 8'hE4},
      '{8'h32, 8'h00, 1, 8'h00}, '{8'h33, 8'hA5, 1, 8'hA5},
      '{8'h36, 8'hFF, 1, 8'h00}, '{8'h50, 8'h5A, 1, 8'h00},
      '{8'h33, 8'h07, 1, 8'h07}};
   audio_adc_interrupt_logic #(.PULSE_HIGH_CYC(4), .PULSE_PERIOD_CYC(8)) dut_u (
      .I_CLK(clk), .I_RSTN(rstn), .I_ADDR(addr), .I_WR(wr), .I_RD(rd),
      .I_WDATA(wdata), .O_RDATA(rdata), .O_RVALID(rvalid),
      .I_EVT_CLK_ERR(evt[4]), .I_EVT_PLL_LOCK(evt[3]), .I_EVT_MIX_SAT(evt[2]),
      .I_EVT_VAD_UP(evt[1]), .I_EVT_VAD_DOWN(evt[0]), .O_MFP1_OUT(out),
      .O_MFP1_OE_N(oe_n), .O_IRQ_ASSERTED(irq));
   irq_host_model host_u (.i_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid),
      .i_pin_out(out), .i_pin_oe_n(oe_n), .o_addr(addr), .o_wr(wr),
      .o_rd(rd), .o_wdata(wdata), .o_pin(pin));
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic fire(input int i);
      cyc(1);
      evt[i] = 1'b1;
      cyc(1);
      evt[i] = 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      host_u.rd(a, got);
      `CHK(got, e)
   endtask
   // bounded so a stuck interrupt cannot hang the run
   task automatic run_len(input logic v, output int k);
      k = 0;
      while (irq === v && k < 50) begin
         k++;
         cyc(1);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      #100000;
      mismatches++;
      stop_test();
   end
   initial begin
      rstn = 1'b0;
      evt = 5'h00;
      cyc(3);
      rstn = 1'b1;
      foreach (rows[i]) begin
         if (rows[i].w)
            host_u.wr(rows[i].a, rows[i].d);
         rd_chk(rows[i].a, rows[i].e);
      end
      host_u.wr(8'h33, 8'hFF);
      for (int i = 4; i >= 0; i--) begin
         fire(i);
         rd_chk(8'h36, 8'h08 << i);
         rd_chk(8'h36, 8'h00);
      end
      `CHK(irq, 1'b0)
      host_u.wr(8'h33, 8'h7F);
      fire(4);
      cyc(1);
      `CHK({irq, pin}, 2'b10)
      host_u.wr(8'h32, 8'h84);
      cyc(1);
      `CHK(pin, 1'b1)
      fire(3);
      rd_chk(8'h36, 8'h80);
      cyc(2);
      `CHK({irq, pin}, 2'b00)
      host_u.wr(8'h32, 8'h00);
      rd_chk(8'h36, 8'h40);
      host_u.wr(8'h32, 8'hE0);
      fire(4);
      cyc(1);
      run_len(1'b1, n);
      `CHK(n, 4)
      fire(3);
      cyc(3);
      `CHK(irq, 1'b0)
      rd_chk(8'h36, 8'hC0);
      host_u.wr(8'h32, 8'h40);
      fire(4);
      run_len(1'b0, n);
      run_len(1'b1, n);
      `CHK(n, 4)
      run_len(1'b0, n);
      `CHK(n, 4)
      rd_chk(8'h36, 8'h80);
      cyc(12);
      `CHK(irq, 1'b0)
      host_u.wr(8'h21, 8'h02);
      cyc(1);
      `CHK({oe_n, pin}, 2'b11)
      host_u.wr(8'h21, 8'h22);
      cyc(1);
      `CHK(oe_n, 1'b0)
      host_u.wr(8'h33, 8'h00);
      rstn = 1'b0;
      cyc(1);
      rstn = 1'b1;
      rd_chk(8'h33, 8'hFF);
      stop_test();
   end
endmodule // testbench
`default_nettype wire
